/* File: hw/gptts_defines.vh */
// register offsets, field positions, reset values and mode codes of the timer
`ifndef GPTTS_DEFINES_VH
`define GPTTS_DEFINES_VH
// register word indices (byte offset is four times the index)
`define GPTTS_CTL_OFF 4'h0
`define GPTTS_AMODE_OFF 4'h1
`define GPTTS_BMODE_OFF 4'h2
`define GPTTS_IMR_OFF 4'h3
`define GPTTS_LOADA_OFF 4'h4
`define GPTTS_LOADB_OFF 4'h5
`define GPTTS_MATCHA_OFF 4'h6
`define GPTTS_MATCHB_OFF 4'h7
`define GPTTS_PRE_OFF 4'h8
`define GPTTS_VALA_OFF 4'h9
`define GPTTS_VALB_OFF 4'hA
`define GPTTS_CNTA_OFF 4'hB
`define GPTTS_CNTB_OFF 4'hC
`define GPTTS_RIS_OFF 4'hD
`define GPTTS_ICR_OFF 4'hE
`define GPTTS_CFG_OFF 4'hF
// control register fields
`define GPTTS_CTL_AEN 0
`define GPTTS_CTL_AOTE 5
`define GPTTS_CTL_BEN 8
`define GPTTS_CTL_BOTE 13
// mode register fields
`define GPTTS_MR_MODE_LO 0
`define GPTTS_MR_MODE_HI 1
`define GPTTS_MR_UP 4
`define GPTTS_MR_MIE 5
`define GPTTS_MR_WOT 6
`define GPTTS_MR_SNAP 7
`define GPTTS_MR_PWM 8
// mode codes
`define GPTTS_MODE_ONESHOT 2'h1
`define GPTTS_MODE_PERIODIC 2'h2
`define GPTTS_MODE_SNAPSHOT 2'h3
// config register: 1 = 32-bit concatenated
`define GPTTS_CFG_32 0
// status / mask bit positions per half
`define GPTTS_IRQ_TOUT 0
`define GPTTS_IRQ_MATCH 1
// reset values
`define GPTTS_RST_LOAD 32'hFFFFFFFF
`define GPTTS_RST_ZERO 32'h00000000
// read answer latency in cycles beyond the request edge
`define GPTTS_WAIT_CYCLES 1
`endif

/* File: hw/gptts_half.v */
// one 16-bit timer half with prescaler, match and timeout detection
`timescale 1ns/1ns
`include "gptts_defines.vh"
module gptts_half (
   clk_sys,
   sys_rst,
   ce,
   run_en,
   count_up,
   chain_in,
   chain_out,
   load_val,
   pre_val,
   match_val,
   wr_val,
   wr_val_data,
   use_pre,
   cnt,
   match_eq,
   tout
);
   input wire clk_sys;
   input wire sys_rst;
   input wire ce;
   input wire run_en;
   input wire count_up;
   input wire chain_in;
   output wire chain_out;
   input wire [15:0] load_val;
   input wire [7:0] pre_val;
   input wire [15:0] match_val;
   input wire wr_val;
   input wire [15:0] wr_val_data;
   input wire use_pre;
   output reg [15:0] cnt;
   output wire match_eq;
   output wire tout;

   reg [7:0] pre_r;
   wire pre_done;
   wire step;
   wire at_end;

   // prescaler tick: gates the step in either count direction when use_pre is set
   assign pre_done = !use_pre || (pre_r == 8'h00);
   assign step = run_en && chain_in && pre_done;
   assign at_end = count_up ? (cnt == load_val) : (cnt == 16'h0000);
   assign tout = step && at_end;
   assign chain_out = tout;
   assign match_eq = (cnt == match_val); // compare ignores run state

   // prescaler counter
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         pre_r <= 8'h00;
      end else if (ce && run_en && chain_in) begin
         pre_r <= pre_done ? pre_val : pre_r - 8'h01;
      end
   end

   // main counter; value writes ignored while counting up
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         cnt <= 16'hFFFF;
      end else if (ce) begin
         if (wr_val && !count_up) begin // up-count writes dropped
            cnt <= wr_val_data;
         end else if (step) begin
            if (at_end) begin
               cnt <= count_up ? 16'h0000 : load_val;
            end else begin
               cnt <= count_up ? cnt + 16'h0001 : cnt - 16'h0001;
            end
         end
      end
   end
endmodule // gptts_half

/* File: hw/gptts_top.v */
// general purpose timer with adc trigger, chaining and snapshot capture
// Overview of operation
// - A match with the adc trigger enabled fires the adc trigger even when the timer is stopped.
// - A match with wait-on-trigger selected fires the chain trigger even when the timer is stopped.
// - The chain trigger is given only while the adc trigger enable is also set.
// - Pwm mode raises match and timeout interrupt flags just as periodic mode does.
// - Pwm mode issues match and timeout dma requests just as periodic mode does.
// - A value write while counting up leaves the running count unchanged.
// - The prescaler is bypassed when counting up in periodic or snapshot mode, in both 16-bit and 32-bit configuration.
// - A 32-bit periodic snapshot with only one half's snapshot enable stores only the low 16 bits.
// - With both snapshot enables set the full 32-bit snapshot is stored in the half a count register.
`timescale 1ns/1ns
`include "gptts_defines.vh"
module gptts_top (
   clk_sys,
   sys_rst,
   clk_en,
   avs_address,
   avs_read,
   avs_write,
   avs_writedata,
   avs_readdata,
   avs_waitrequest,
   adc_trig_a_r,
   adc_trig_b_r,
   wot_trig_a_r,
   wot_trig_b_r,
   dma_req_a_r,
   dma_req_b_r,
   chain_in_a,
   chain_in_b
);
   input wire clk_sys;
   input wire sys_rst;
   input wire clk_en;
   input wire [5:0] avs_address;
   input wire avs_read;
   input wire avs_write;
   input wire [31:0] avs_writedata;
   output reg [31:0] avs_readdata;
   output reg avs_waitrequest;
   output reg adc_trig_a_r;
   output reg adc_trig_b_r;
   output reg wot_trig_a_r;
   output reg wot_trig_b_r;
   output reg dma_req_a_r;
   output reg dma_req_b_r;
   input wire chain_in_a;
   input wire chain_in_b;

   reg [31:0] ctl_r;
   reg [31:0] mode_r [0:1];
   reg [3:0] imr_r;
   reg [31:0] load_r;
   reg [31:0] match_r;
   reg [7:0] pre_r [0:1];
   reg [31:0] snap_r;
   reg [3:0] ris_r;
   reg cfg32_r;
   reg ack_r;
   reg [31:0] rd_nxt;
   reg [3:0] ris_nxt;
   reg [3:0] sts_set;

   wire [3:0] idx;
   wire wr_go;
   wire rd_go;
   wire [15:0] cnt_w [0:1];
   wire [1:0] meq_w;
   wire [1:0] tout_w;
   wire [1:0] chain_w;
   wire [1:0] upw;
   wire [1:0] runw;
   wire [1:0] use_pre_w;
   wire [1:0] wr_val_w;
   wire [1:0] match_ev;
   wire [31:0] cnt32;

   // mode decode used for both halves and snapshot path
   function [1:0] mode_of;
      input [31:0] mr;
      begin
         mode_of = mr[`GPTTS_MR_MODE_HI:`GPTTS_MR_MODE_LO];
      end
   endfunction

   // true for periodic timing, including pwm which behaves alike
   function is_periodic;
      input [31:0] mr;
      begin
         is_periodic = (mode_of(mr) == `GPTTS_MODE_PERIODIC);
      end
   endfunction

   assign idx = avs_address[5:2];
   assign wr_go = avs_write && !ack_r;
   assign rd_go = avs_read && !ack_r;
   assign cnt32 = {cnt_w[1], cnt_w[0]};

   // per-half wiring of the two counters
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_half
         assign upw[g] = mode_r[g][`GPTTS_MR_UP];
         assign runw[g] = ctl_r[g * 8];
         // prescaler forced off in up-counting periodic/snapshot modes
         assign use_pre_w[g] = !(upw[g] && ((mode_of(mode_r[g]) ==
                               `GPTTS_MODE_PERIODIC) || (mode_of(mode_r[g])
                               == `GPTTS_MODE_SNAPSHOT))) &&
                               (pre_r[g] != 8'h00);
         assign wr_val_w[g] = clk_en && wr_go && (idx == (g == 0 ?
                              `GPTTS_VALA_OFF : `GPTTS_VALB_OFF));
         assign match_ev[g] = meq_w[g] && runw[g];
         gptts_half u_half (
            .clk_sys(clk_sys),
            .sys_rst(sys_rst),
            .ce(clk_en),
            .run_en(runw[g]),
            .count_up(upw[g]),
            .chain_in(g == 0 ? (cfg32_r ? 1'b1 : chain_in_a) :
                      (cfg32_r ? tout_w[0] : chain_in_b)),
            .chain_out(chain_w[g]),
            .load_val(load_r[g * 16 +: 16]),
            .pre_val(pre_r[g]),
            .match_val(match_r[g * 16 +: 16]),
            .wr_val(wr_val_w[g]),
            .wr_val_data(avs_writedata[15:0]),
            .use_pre(use_pre_w[g]),
            .cnt(cnt_w[g]),
            .match_eq(meq_w[g]),
            .tout(tout_w[g])
         );
      end
   endgenerate

   // raw status set terms; pwm is not filtered out
   always @* begin
      sts_set = 4'h0;
      sts_set[`GPTTS_IRQ_TOUT] = tout_w[0];
      sts_set[`GPTTS_IRQ_MATCH] = match_ev[0] &&
                                  mode_r[0][`GPTTS_MR_MIE];
      sts_set[2 + `GPTTS_IRQ_TOUT] = tout_w[1];
      sts_set[2 + `GPTTS_IRQ_MATCH] = match_ev[1] &&
                                      mode_r[1][`GPTTS_MR_MIE];
   end

   // sticky status: write-one clears, a same-cycle event wins
   always @* begin
      ris_nxt = ris_r;
      if (wr_go && idx == `GPTTS_ICR_OFF) begin
         ris_nxt = ris_r & ~avs_writedata[3:0];
      end
      ris_nxt = ris_nxt | sts_set;
   end

   // read mux
   always @* begin
      rd_nxt = 32'h00000000;
      case (idx)
         `GPTTS_CTL_OFF: rd_nxt = ctl_r;
         `GPTTS_AMODE_OFF: rd_nxt = mode_r[0];
         `GPTTS_BMODE_OFF: rd_nxt = mode_r[1];
         `GPTTS_IMR_OFF: rd_nxt = {28'h0000000, imr_r};
         `GPTTS_LOADA_OFF: rd_nxt = {16'h0000, load_r[15:0]};
         `GPTTS_LOADB_OFF: rd_nxt = {16'h0000, load_r[31:16]};
         `GPTTS_MATCHA_OFF: rd_nxt = {16'h0000, match_r[15:0]};
         `GPTTS_MATCHB_OFF: rd_nxt = {16'h0000, match_r[31:16]};
         `GPTTS_PRE_OFF: rd_nxt = {16'h0000, pre_r[1], pre_r[0]};
         `GPTTS_VALA_OFF: rd_nxt = {16'h0000, cnt_w[0]};
         `GPTTS_VALB_OFF: rd_nxt = {16'h0000, cnt_w[1]};
         `GPTTS_CNTA_OFF: rd_nxt = snap_r;
         `GPTTS_CNTB_OFF: rd_nxt = {16'h0000, cnt_w[1]};
         `GPTTS_RIS_OFF: rd_nxt = {28'h0000000, ris_r};
         `GPTTS_CFG_OFF: rd_nxt = {31'h00000000, cfg32_r};
         default: rd_nxt = 32'h00000000;
      endcase
   end

   // avalon slave handshake: one wait state per access
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         ack_r <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end else if (clk_en) begin
         ack_r <= (avs_read || avs_write) && !ack_r;
         avs_waitrequest <= !((avs_read || avs_write) && !ack_r);
         if (rd_go) begin
            avs_readdata <= rd_nxt;
         end
      end
   end

   // register writes
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         ctl_r <= `GPTTS_RST_ZERO;
         mode_r[0] <= `GPTTS_RST_ZERO;
         mode_r[1] <= `GPTTS_RST_ZERO;
         imr_r <= 4'h0;
         load_r <= `GPTTS_RST_LOAD;
         match_r <= `GPTTS_RST_LOAD;
         pre_r[0] <= 8'h00;
         pre_r[1] <= 8'h00;
         cfg32_r <= 1'b0;
         ris_r <= 4'h0;
      end else if (clk_en) begin
         ris_r <= ris_nxt;
         if (wr_go) begin
            case (idx)
               `GPTTS_CTL_OFF: ctl_r <= avs_writedata;
               `GPTTS_AMODE_OFF: mode_r[0] <= avs_writedata;
               `GPTTS_BMODE_OFF: mode_r[1] <= avs_writedata;
               `GPTTS_IMR_OFF: imr_r <= avs_writedata[3:0];
               `GPTTS_LOADA_OFF: load_r[15:0] <= avs_writedata[15:0];
               `GPTTS_LOADB_OFF: load_r[31:16] <= avs_writedata[15:0];
               `GPTTS_MATCHA_OFF: match_r[15:0] <= avs_writedata[15:0];
               `GPTTS_MATCHB_OFF: match_r[31:16] <= avs_writedata[15:0];
               `GPTTS_PRE_OFF: begin
                  pre_r[0] <= avs_writedata[7:0];
                  pre_r[1] <= avs_writedata[15:8];
               end
               `GPTTS_CFG_OFF: cfg32_r <= avs_writedata[`GPTTS_CFG_32];
               default: ;
            endcase
         end
      end
   end

   // snapshot capture on half a timeout
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         snap_r <= `GPTTS_RST_ZERO;
      end else if (clk_en) begin
         if (cfg32_r && is_periodic(mode_r[0]) && tout_w[0] &&
             (mode_r[0][`GPTTS_MR_SNAP] ||
              mode_r[1][`GPTTS_MR_SNAP])) begin
            if (mode_r[0][`GPTTS_MR_SNAP] && mode_r[1][`GPTTS_MR_SNAP]) begin
               snap_r <= cnt32; // both enables give full width
            end else begin
               snap_r <= {16'h0000, cnt32[15:0]}; // single enable
            end
         end else if (!cfg32_r || !mode_r[0][`GPTTS_MR_SNAP]) begin
            snap_r <= {16'h0000, cnt_w[0]};
         end
      end
   end

   // trigger and request outputs
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         adc_trig_a_r <= 1'b0;
         adc_trig_b_r <= 1'b0;
         wot_trig_a_r <= 1'b0;
         wot_trig_b_r <= 1'b0;
         dma_req_a_r <= 1'b0;
         dma_req_b_r <= 1'b0;
      end else if (clk_en) begin
         // match fires regardless of run enable
         adc_trig_a_r <= meq_w[0] && ctl_r[`GPTTS_CTL_AOTE];
         adc_trig_b_r <= meq_w[1] && ctl_r[`GPTTS_CTL_BOTE];
         // chain trigger needs match, wot and trigger enable
         wot_trig_a_r <= meq_w[0] && mode_r[0][`GPTTS_MR_WOT] &&
                         ctl_r[`GPTTS_CTL_AOTE];
         wot_trig_b_r <= meq_w[1] && mode_r[1][`GPTTS_MR_WOT] &&
                         ctl_r[`GPTTS_CTL_BOTE];
         // dma requests also in pwm mode
         dma_req_a_r <= |(sts_set[1:0] & imr_r[1:0]);
         dma_req_b_r <= |(sts_set[3:2] & imr_r[3:2]);
      end
   end
endmodule // gptts_top

/* File: sim/gp_timer_trigger_snapshot_bench.sv */
// self-checking bench for the timer with adc trigger and snapshot
`timescale 1ns/1ns
`include "gptts_defines.vh"
module gp_timer_trigger_snapshot_bench;
   reg clk_sys, sys_rst, avs_read, avs_write;
   reg [5:0] avs_address;
   reg [31:0] avs_writedata, q, v0, r;
   wire [31:0] avs_readdata;
   wire avs_waitrequest, ta, tb, wa, wb, da, db;
   integer bad_count, checks_done, seed, cyc, h, i, ld, d0, adc_cnt, dma_cnt;
   gptts_top DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(1'b1),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .adc_trig_a_r(ta), .adc_trig_b_r(tb), .wot_trig_a_r(wa),
      .wot_trig_b_r(wb), .dma_req_a_r(da), .dma_req_b_r(db),
      .chain_in_a(1'b1), .chain_in_b(1'b1));
   gptts_far far (.clk_sys(clk_sys), .sys_rst(sys_rst), .adc_trig_a_r(ta),
      .dma_req_a_r(da), .adc_cnt(adc_cnt), .dma_cnt(dma_cnt));
   // clock generation
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task print_verdict;
      begin
         if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
         else $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // one avalon access, held until waitrequest is sampled low
   task bus(input wr, input [3:0] idx, input [31:0] d, output [31:0] rd);
      begin
         @(posedge clk_sys);
         avs_address <= {idx, 2'b00};
         avs_writedata <= d;
         avs_write <= wr;
         avs_read <= !wr;
         @(posedge clk_sys);
         while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
         rd = avs_readdata;
         avs_write <= 1'b0;
         avs_read <= 1'b0;
      end
   endtask
   task wait_c(input integer n);
      repeat (n) @(posedge clk_sys);
   endtask
   // hang guard
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         bad_count = bad_count + 1;
         print_verdict;
      end
   end
   initial begin
      bad_count = 0;
      checks_done = 0;
      cyc = 0;
      seed = 20;
      sys_rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 6'h00;
      avs_writedata = 32'h00000000;
      wait_c(4);
      sys_rst <= 1'b0;
      // stopped timer, counter equals match: triggers per half
      for (h = 0; h < 2; h = h + 1) begin
         bus(1, `GPTTS_CTL_OFF, h ? 32'h00002000 : 32'h00000020, q);
         wait_c(3);
         chk(h ? tb : ta, 1);
         chk(h ? wb : wa, 0);
         bus(1, h ? `GPTTS_BMODE_OFF : `GPTTS_AMODE_OFF, 32'h00000040, q);
         wait_c(3);
         chk(h ? wb : wa, 1);
         bus(1, `GPTTS_CTL_OFF, 32'h00000000, q);
         wait_c(3);
         chk(h ? wb : wa, 0);
         bus(1, h ? `GPTTS_BMODE_OFF : `GPTTS_AMODE_OFF, 32'h00000000, q);
      end
      chk(adc_cnt, 1);
      // value write while counting up
      bus(1, `GPTTS_AMODE_OFF, 32'h00000012, q);
      bus(0, `GPTTS_CNTA_OFF, 32'h00000000, v0);
      r = $random(seed) & 32'h00007FFF;
      bus(1, `GPTTS_VALA_OFF, r, q);
      wait_c(2);
      bus(0, `GPTTS_CNTA_OFF, 32'h00000000, q);
      chk(q, v0);
      // pwm mode timeouts: flag and dma as periodic, masked on last pass
      for (i = 0; i < 3; i = i + 1) begin
         ld = 4 + ($random(seed) & 7);
         bus(1, `GPTTS_AMODE_OFF, 32'h00000102, q);
         bus(1, `GPTTS_LOADA_OFF, ld, q);
         bus(1, `GPTTS_VALA_OFF, ld, q);
         bus(1, `GPTTS_ICR_OFF, 32'h0000000F, q);
         bus(1, `GPTTS_IMR_OFF, (i == 2) ? 32'h0 : 32'h1, q);
         d0 = dma_cnt;
         bus(1, `GPTTS_CTL_OFF, 32'h00000001, q);
         wait_c(3 * ld + 10);
         bus(1, `GPTTS_CTL_OFF, 32'h00000000, q);
         bus(0, `GPTTS_RIS_OFF, 32'h00000000, q);
         chk(q[0], 1);
         chk(dma_cnt > d0, i != 2);
         chk(db, 0);
      end
      // 32-bit periodic snapshot, one enable then both
      bus(1, `GPTTS_IMR_OFF, 32'h00000000, q);
      bus(1, `GPTTS_CFG_OFF, 32'h00000001, q);
      bus(1, `GPTTS_LOADA_OFF, 32'h00000004, q);
      bus(1, `GPTTS_AMODE_OFF, 32'h00000082, q);
      bus(1, `GPTTS_VALA_OFF, 32'h00000004, q);
      bus(1, `GPTTS_CTL_OFF, 32'h00000001, q);
      wait_c(40);
      bus(0, `GPTTS_CNTA_OFF, 32'h00000000, q);
      chk(q[31:16], 16'h0000);
      bus(1, `GPTTS_BMODE_OFF, 32'h00000082, q);
      wait_c(40);
      bus(0, `GPTTS_CNTA_OFF, 32'h00000000, q);
      chk(q[31:16] != 16'h0000, 1);
      // up-count periodic with a large prescale must still step every cycle
      bus(1, `GPTTS_CTL_OFF, 32'h00000000, q);
      bus(1, `GPTTS_CFG_OFF, 32'h00000000, q);
      bus(1, `GPTTS_LOADA_OFF, 32'h0000FFFF, q);
      bus(1, `GPTTS_PRE_OFF, 32'h000000FF, q);
      bus(1, `GPTTS_AMODE_OFF, 32'h00000012, q);
      bus(1, `GPTTS_CTL_OFF, 32'h00000001, q);
      bus(0, `GPTTS_VALA_OFF, 32'h00000000, v0);
      wait_c(20);
      bus(0, `GPTTS_VALA_OFF, 32'h00000000, q);
      chk((q - v0) >= 20, 1);
      // trigger enabled only after the timer runs; no match, no trigger
      bus(1, `GPTTS_CTL_OFF, 32'h00000021, q);
      wait_c(3);
      chk(ta, 0);
      print_verdict;
   end
endmodule // gp_timer_trigger_snapshot_bench

/* File: sim/gptts_chk.sv */
// port checker for the timer top, bound beside it
`timescale 1ns/1ns
module gptts_chk (
   input wire clk_sys,
   input wire sys_rst,
   input wire clk_en,
   input wire [5:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [31:0] avs_readdata,
   input wire avs_waitrequest,
   input wire adc_trig_a_r,
   input wire adc_trig_b_r,
   input wire wot_trig_a_r,
   input wire wot_trig_b_r,
   input wire dma_req_a_r,
   input wire dma_req_b_r,
   input wire chain_in_a,
   input wire chain_in_b
);
   // all checks in the one clock domain, frozen while stalled
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst || !clk_en);
   a_wot_needs_a: assert property (wot_trig_a_r |-> adc_trig_a_r)
      else $error("chain trigger a without adc trigger");
   a_wot_needs_b: assert property (wot_trig_b_r |-> adc_trig_b_r)
      else $error("chain trigger b without adc trigger");
   a_ack_one_cycle: assert property ($rose(avs_read || avs_write) |=>
      !avs_waitrequest ##1 avs_waitrequest)
      else $error("access not answered in one cycle");
   a_ack_has_cause: assert property (!avs_waitrequest |->
      $past(avs_read || avs_write))
      else $error("answer without request");
   a_ack_idle_high: assert property (!(avs_read || avs_write) ##1
      !(avs_read || avs_write) |-> avs_waitrequest)
      else $error("waitrequest low at rest");
   a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
      else $error("read data changed without read");
   a_dma_pulse_a: assert property (dma_req_a_r |=> !dma_req_a_r)
      else $error("dma request a not a pulse");
   a_dma_pulse_b: assert property (dma_req_b_r |=> !dma_req_b_r)
      else $error("dma request b not a pulse");
   // main scenarios reached
   c_wot_a: cover property (wot_trig_a_r);
   c_adc_b: cover property (adc_trig_b_r);
   c_dma_a: cover property (dma_req_a_r);
endmodule // gptts_chk
bind gptts_top gptts_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .adc_trig_a_r(adc_trig_a_r), .adc_trig_b_r(adc_trig_b_r),
   .wot_trig_a_r(wot_trig_a_r), .wot_trig_b_r(wot_trig_b_r),
   .dma_req_a_r(dma_req_a_r), .dma_req_b_r(dma_req_b_r),
   .chain_in_a(chain_in_a), .chain_in_b(chain_in_b));

/* File: sim/gptts_far.sv */
// adc trigger and dma request side: counts what it receives
`timescale 1ns/1ns
module gptts_far (
   input wire clk_sys,
   input wire sys_rst,
   input wire adc_trig_a_r,
   input wire dma_req_a_r,
   output integer adc_cnt,
   output integer dma_cnt
);
   reg adc_q_r;
   // adc starts on a rising trigger, dma serves every pulse
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         adc_q_r <= 1'b0;
         adc_cnt <= 0;
         dma_cnt <= 0;
      end else begin
         adc_q_r <= adc_trig_a_r;
         if (adc_trig_a_r && !adc_q_r) adc_cnt <= adc_cnt + 1;
         if (dma_req_a_r) dma_cnt <= dma_cnt + 1;
      end
   end
endmodule // gptts_far
